// ===== src/ufcs_dev_end.sv
// serial port: control, status, frame format, tx and rx with queue
`timescale 1ns/100ps
module ufcs_dev_end #(
  parameter int unsigned HALF_BIT = ufcs_pkg::HALF_BIT_DEF
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  output logic irq_req,
  ufcs_link_if.dev link
);
  typedef struct packed {
    logic [1:0] sync;
    logic [29:0] aidx;
    logic wr_pend;
    logic [7:0] rdat;
    ufcs_pkg::ufcs_scs_t scs;
    ufcs_pkg::ufcs_ffc_t ffc;
    logic hold_full;
    logic [7:0] hold;
    ufcs_pkg::ufcs_st_t tx_st;
    logic [ufcs_pkg::FRAME_W-1:0] frame;
    logic [4:0] tx_cnt;
    logic [4:0] tx_pre;
    logic [4:0] tx_end;
    logic line;
    ufcs_pkg::ufcs_st_t rx_st;
    logic [4:0] rx_cnt;
    logic [ufcs_pkg::FRAME_W-1:0] bits;
    ufcs_pkg::ufcs_ent_t [2:0] fifo;
    logic [1:0] rp;
    logic [1:0] cnt;
    logic irq;
  } ufcs_dev_st_t;

  ufcs_dev_st_t q, d;
  logic tx_load, rx_start, tx_tick, rx_tick;

  localparam logic [1:0] FIFO_LAST = ufcs_pkg::FIFO_DEPTH - 2'h1;
  function automatic logic [1:0] ufcs_nxt(input logic [1:0] p);
    return (p == FIFO_LAST) ? 2'h0 : p + 2'h1;
  endfunction

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = {24'h000000, q.rdat};
  assign irq_req = q.irq;
  assign link.dev_tx = q.line;

  ufcs_half_tick #(.HALF_BIT(HALF_BIT)) u_tx_tick (
    .hclk(hclk), .hresetn(hresetn), .restart(tx_load), .tick(tx_tick)
  );
  ufcs_half_tick #(.HALF_BIT(HALF_BIT)) u_rx_tick (
    .hclk(hclk), .hresetn(hresetn), .restart(rx_start), .tick(rx_tick)
  );

  always_comb begin
    ufcs_pkg::ufcs_scs_t ws;
    ufcs_pkg::ufcs_ent_t ent;
    logic take, pop, push, ext_en, hchg, xb;
    logic ovr_set, ri_set, ti_set, perr_set;
    logic [4:0] c;
    logic [3:0] slot;
    logic [1:0] wp;
    logic [7:0] dat;
    ws = '0;
    ent = '0;
    pop = 1'b0;
    push = 1'b0;
    ovr_set = 1'b0;
    ri_set = 1'b0;
    ti_set = 1'b0;
    c = '0;
    dat = '0;
    xb = 1'b0;
    take = 1'b0;
    hchg = 1'b0;
    perr_set = 1'b0;
    d = q;
    ext_en = q.ffc.pe | q.ffc.xbe;
    slot = ufcs_pkg::ufcs_ext_slot(q.ffc.dl);
    wp = (q.cnt == 2'h0) ? q.rp :
        (q.cnt == 2'h1) ? ufcs_nxt(q.rp) : ufcs_nxt(ufcs_nxt(q.rp));
    d.sync = {q.sync[0], link.node_tx};
    // ----------------------------------------------------------
    // bus address phase: reads answer from here
    // ----------------------------------------------------------
    take = hsel & hready & htrans[1];
    d.wr_pend = take & hwrite;
    if (take) begin
      d.aidx = haddr[31:2];
    end
    if (take && !hwrite) begin
      case (haddr[31:2])
        ufcs_pkg::IDX_SCS: d.rdat = q.scs;
        ufcs_pkg::IDX_FFC: d.rdat = q.ffc;
        ufcs_pkg::IDX_SDB: begin
          // queue stays readable, read pops the head
          pop = (q.cnt != 2'h0);
          d.rdat = pop ? q.fifo[q.rp].data : 8'h00;
        end
        default: d.rdat = 8'h00;
      endcase
    end
    // ----------------------------------------------------------
    // transmit: holding register into shifter
    // ----------------------------------------------------------
    tx_load = (q.tx_st == ufcs_pkg::ST_IDLE) & q.hold_full;
    if (tx_load) begin
      // extra slot carries control or parity
      d.frame = ufcs_pkg::ufcs_frame(q.hold, q.ffc.dl, ext_en,
          q.ffc.pe ? ufcs_pkg::ufcs_parity(q.hold, q.ffc.dl, q.ffc.pt)
          : q.scs.tbx);
      d.tx_pre = ufcs_pkg::ufcs_pre(q.ffc.dl, ext_en);
      d.tx_end = ufcs_pkg::ufcs_pre(q.ffc.dl, ext_en)
          + ufcs_pkg::ufcs_stop(q.ffc.dl, q.ffc.sbl);
      d.tx_cnt = '0;
      d.tx_st = ufcs_pkg::ST_RUN;
      d.hold_full = 1'b0;
      d.line = 1'b0;
    end else if (q.tx_st == ufcs_pkg::ST_RUN && tx_tick) begin
      c = q.tx_cnt + 5'h01;
      d.tx_cnt = c;
      d.line = q.frame[c[4:1]];
      // done flag at start of stop bit
      ti_set = (c == q.tx_pre);
      if (c == q.tx_end) begin
        d.tx_st = ufcs_pkg::ST_IDLE;
        d.line = 1'b1;
      end
    end
    // ----------------------------------------------------------
    // receive: mid-bit sampling of the synced line
    // ----------------------------------------------------------
    // no new frame while reception disabled
    rx_start = (q.rx_st == ufcs_pkg::ST_IDLE) & q.scs.ren & ~q.sync[1];
    if (rx_start) begin
      d.rx_st = ufcs_pkg::ST_RUN;
      d.rx_cnt = '0;
    end else if (q.rx_st == ufcs_pkg::ST_RUN && rx_tick) begin
      c = q.rx_cnt + 5'h01;
      d.rx_cnt = c;
      if (c[0]) begin
        d.bits[c[4:1]] = q.sync[1];
        if (c[4:1] == '0 && q.sync[1]) begin
          d.rx_st = ufcs_pkg::ST_IDLE;
        end else if (c[4:1] == slot + {3'h0, ext_en}) begin
          d.rx_st = ufcs_pkg::ST_IDLE;
          dat = q.bits[8:1] & ufcs_pkg::ufcs_mask(q.ffc.dl);
          // extra bit, else first stop level
          xb = ext_en ? q.bits[slot] : q.sync[1];
          ent.data = dat;
          ent.xbit = xb;
          ent.perr = q.ffc.pe && q.bits[slot] !=
              ufcs_pkg::ufcs_parity(dat, q.ffc.dl, q.ffc.pt);
          // store only with room and high stop
          push = q.sync[1] && q.cnt != ufcs_pkg::FIFO_DEPTH;
          ovr_set = q.sync[1] && q.cnt == ufcs_pkg::FIFO_DEPTH;
          ri_set = push && (!q.ffc.mce || xb);
        end
      end
    end
    // ----------------------------------------------------------
    // receive queue
    // ----------------------------------------------------------
    if (pop) begin
      d.rp = ufcs_nxt(q.rp);
    end
    if (push) begin
      d.fifo[wp] = ent;
    end
    d.cnt = q.cnt - {1'b0, pop} + {1'b0, push};
    hchg = (pop | (push & (q.cnt == 2'h0))) & (d.cnt != 2'h0);
    // flag raised as errored byte becomes oldest
    perr_set = hchg & d.fifo[d.rp].perr;
    // ----------------------------------------------------------
    // bus data phase writes, then hardware sets win
    // ----------------------------------------------------------
    if (q.wr_pend) begin
      ws = hwdata[7:0];
      case (q.aidx)
        ufcs_pkg::IDX_SCS: begin
          d.scs.ovr = ws.ovr;
          d.scs.perr = ws.perr;
          d.scs.ren = ws.ren;
          d.scs.tbx = ws.tbx;
          d.scs.ti = ws.ti;
          d.scs.ri = ws.ri;
        end
        ufcs_pkg::IDX_FFC: d.ffc = hwdata[7:0];
        ufcs_pkg::IDX_SDB: begin
          // write ignored while holding register occupied
          if (!q.hold_full) begin
            d.hold = hwdata[7:0];
            d.hold_full = 1'b1;
          end
        end
        default: d.hold = d.hold;
      endcase
    end
    d.scs.ovr = d.scs.ovr | ovr_set;
    d.scs.perr = d.scs.perr | perr_set;
    d.scs.ti = d.scs.ti | ti_set;
    // held while more than read head queued
    d.scs.ri = d.scs.ri | ri_set | (d.cnt > 2'h1);
    d.scs.thre = ~d.hold_full;
    d.scs.rbx = d.fifo[d.rp].xbit;
    // done flags request the port interrupt
    d.irq = d.scs.ti | d.scs.ri;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q <= '0;
      q.scs <= ufcs_pkg::SCS_RST;
      q.ffc <= ufcs_pkg::FFC_RST;
      q.sync <= 2'h3;
      q.line <= 1'b1;
    end else begin
      q <= d;
    end
  end
endmodule

// ===== src/ufcs_pkg.sv
// shared constants, types and frame helpers of the serial port
package ufcs_pkg;
  // ------------------------------------------------------------
  // register map: word index, byte address is four times it
  // ------------------------------------------------------------
  localparam logic [29:0] IDX_SCS = 30'h0000098;
  localparam logic [29:0] IDX_SDB = 30'h0000099;
  localparam logic [29:0] IDX_FFC = 30'h00000A9;
  localparam logic [7:0] SCS_RST = 8'h20;
  localparam logic [7:0] FFC_RST = 8'h0C;

  // ------------------------------------------------------------
  // field layouts
  // ------------------------------------------------------------
  typedef struct packed {
    logic ovr;
    logic perr;
    logic thre;
    logic ren;
    logic tbx;
    logic rbx;
    logic ti;
    logic ri;
  } ufcs_scs_t;

  typedef struct packed {
    logic mce;
    logic [1:0] pt;
    logic pe;
    logic [1:0] dl;
    logic xbe;
    logic sbl;
  } ufcs_ffc_t;

  typedef struct packed {
    logic [7:0] data;
    logic xbit;
    logic perr;
  } ufcs_ent_t;

  typedef enum logic {ST_IDLE = 1'b0, ST_RUN = 1'b1} ufcs_st_t;

  // ------------------------------------------------------------
  // codes and counts
  // ------------------------------------------------------------
  localparam logic [1:0] PT_ODD = 2'h0;
  localparam logic [1:0] PT_EVEN = 2'h1;
  localparam logic [1:0] PT_MARK = 2'h2;
  localparam logic [1:0] DL_FIVE = 2'h0;
  localparam logic [1:0] DL_MAX = 2'h3;
  localparam logic [1:0] FIFO_DEPTH = 2'h3;
  localparam logic [3:0] BASE_SLOTS = 4'h6;
  localparam logic [4:0] STOP_ONE = 5'h02;
  localparam logic [4:0] STOP_MID = 5'h03;
  localparam logic [4:0] STOP_TWO = 5'h04;
  localparam int unsigned FRAME_W = 12;
  localparam int unsigned HALF_BIT_DEF = 8;

  // ------------------------------------------------------------
  // frame helpers
  // ------------------------------------------------------------
  function automatic logic [7:0] ufcs_mask(input logic [1:0] dl);
    return 8'hFF >> (DL_MAX - dl);
  endfunction

  function automatic logic ufcs_parity(input logic [7:0] d,
      input logic [1:0] dl, input logic [1:0] pt);
    logic [7:0] m;
    m = d & ufcs_mask(dl);
    case (pt)
      PT_ODD: return ~^m;
      PT_EVEN: return ^m;
      PT_MARK: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction

  // slot of the bit after the data field; slot 0 is the start bit
  function automatic logic [3:0] ufcs_ext_slot(input logic [1:0] dl);
    return {2'h0, dl} + BASE_SLOTS;
  endfunction

  function automatic logic [FRAME_W-1:0] ufcs_frame(input logic [7:0] d,
      input logic [1:0] dl, input logic ext_en, input logic ext_bit);
    logic [FRAME_W-1:0] f;
    f = '1;
    f[0] = 1'b0;
    for (int i = 0; i < 8; i++) begin
      if (i < int'(ufcs_ext_slot(dl)) - 1) begin
        f[i+1] = d[i];
      end
    end
    if (ext_en) begin
      f[ufcs_ext_slot(dl)] = ext_bit;
    end
    return f;
  endfunction

  // half bits from start edge to the start of the stop bit
  function automatic logic [4:0] ufcs_pre(input logic [1:0] dl,
      input logic ext_en);
    return {ufcs_ext_slot(dl) + {3'h0, ext_en}, 1'b0};
  endfunction

  function automatic logic [4:0] ufcs_stop(input logic [1:0] dl,
      input logic sbl);
    if (!sbl) begin
      return STOP_ONE;
    end
    return (dl == DL_FIVE) ? STOP_MID : STOP_TWO;
  endfunction
endpackage

// ===== src/ufcs_link_if.sv
// serial line pair between the port and the remote node
`timescale 1ns/100ps
interface ufcs_link_if;
  logic dev_tx;
  logic node_tx;
  modport dev (output dev_tx, input node_tx);
  modport node (input dev_tx, output node_tx);
endinterface

// ===== src/ufcs_half_tick.sv
// half-bit tick generator with synchronous restart
`timescale 1ns/100ps
module ufcs_half_tick #(
  parameter int unsigned HALF_BIT = ufcs_pkg::HALF_BIT_DEF
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic restart,
  output logic tick
);
  generate
    if (HALF_BIT < 2 || HALF_BIT > 65535) begin : g_bad
      $error("HALF_BIT must lie in 2..65535");
    end
  endgenerate

  typedef struct packed {
    logic [15:0] cnt;
  } ufcs_tick_st_t;

  ufcs_tick_st_t q, d;

  always_comb begin
    d = q;
    tick = 1'b0;
    if (restart) begin
      d.cnt = '0;
    end else if (q.cnt == 16'(HALF_BIT - 1)) begin
      tick = 1'b1;
      d.cnt = '0;
    end else begin
      d.cnt = q.cnt + 16'h0001;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
endmodule

// ===== src/ufcs_node_end.sv
// remote serial node: frames bytes out and checks frames in
`timescale 1ns/100ps
module ufcs_node_end #(
  parameter int unsigned HALF_BIT = ufcs_pkg::HALF_BIT_DEF
) (
  input wire logic hclk,
  input wire logic hresetn,
  ufcs_link_if.node link,
  input wire logic [1:0] data_length_sel,
  input wire logic parity_enable_bit,
  input wire logic [1:0] parity_type_sel,
  input wire logic extra_bit_mode,
  input wire logic stop_length_sel,
  input wire logic tx_valid,
  output logic tx_ready,
  input wire logic [7:0] tx_data,
  input wire logic tx_extra,
  output logic rx_valid,
  output logic [7:0] rx_data,
  output logic rx_extra,
  output logic rx_parity_err,
  output logic rx_stop_err
);
  typedef struct packed {
    logic [1:0] sync;
    ufcs_pkg::ufcs_st_t tx_st;
    logic [ufcs_pkg::FRAME_W-1:0] frame;
    logic [4:0] tx_cnt;
    logic [4:0] tx_end;
    logic line;
    ufcs_pkg::ufcs_st_t rx_st;
    logic [4:0] rx_cnt;
    logic [ufcs_pkg::FRAME_W-1:0] bits;
    logic vld;
    logic [7:0] data;
    logic xbit;
    logic perr;
    logic serr;
  } ufcs_node_st_t;

  ufcs_node_st_t q, d;
  logic tx_load, rx_start, tx_tick, rx_tick;
  logic ext_en;
  logic [3:0] slot;

  assign ext_en = parity_enable_bit | extra_bit_mode;
  assign slot = ufcs_pkg::ufcs_ext_slot(data_length_sel);
  assign tx_ready = (q.tx_st == ufcs_pkg::ST_IDLE);
  assign link.node_tx = q.line;
  assign rx_valid = q.vld;
  assign rx_data = q.data;
  assign rx_extra = q.xbit;
  assign rx_parity_err = q.perr;
  assign rx_stop_err = q.serr;

  ufcs_half_tick #(.HALF_BIT(HALF_BIT)) u_tx_tick (
    .hclk(hclk), .hresetn(hresetn), .restart(tx_load), .tick(tx_tick)
  );
  ufcs_half_tick #(.HALF_BIT(HALF_BIT)) u_rx_tick (
    .hclk(hclk), .hresetn(hresetn), .restart(rx_start), .tick(rx_tick)
  );

  always_comb begin
    logic [4:0] c;
    logic [7:0] dat;
    c = '0;
    dat = '0;
    d = q;
    d.vld = 1'b0;
    d.sync = {q.sync[0], link.dev_tx};
    // ----------------------------------------------------------
    // transmit
    // ----------------------------------------------------------
    tx_load = tx_valid & tx_ready;
    if (tx_load) begin
      // start, data lsb first, extra, stop
      d.frame = ufcs_pkg::ufcs_frame(tx_data, data_length_sel, ext_en,
          parity_enable_bit ? ufcs_pkg::ufcs_parity(tx_data,
          data_length_sel, parity_type_sel) : tx_extra);
      d.tx_end = ufcs_pkg::ufcs_pre(data_length_sel, ext_en)
          + ufcs_pkg::ufcs_stop(data_length_sel, stop_length_sel);
      d.tx_cnt = '0;
      d.tx_st = ufcs_pkg::ST_RUN;
      d.line = 1'b0;
    end else if (q.tx_st == ufcs_pkg::ST_RUN && tx_tick) begin
      c = q.tx_cnt + 5'h01;
      d.tx_cnt = c;
      d.line = q.frame[c[4:1]];
      if (c == q.tx_end) begin
        d.tx_st = ufcs_pkg::ST_IDLE;
        d.line = 1'b1;
      end
    end
    // ----------------------------------------------------------
    // receive
    // ----------------------------------------------------------
    rx_start = (q.rx_st == ufcs_pkg::ST_IDLE) & ~q.sync[1];
    if (rx_start) begin
      d.rx_st = ufcs_pkg::ST_RUN;
      d.rx_cnt = '0;
    end else if (q.rx_st == ufcs_pkg::ST_RUN && rx_tick) begin
      c = q.rx_cnt + 5'h01;
      d.rx_cnt = c;
      if (c[0]) begin
        d.bits[c[4:1]] = q.sync[1];
        if (c[4:1] == '0 && q.sync[1]) begin
          d.rx_st = ufcs_pkg::ST_IDLE;
        end else if (c[4:1] == slot + {3'h0, ext_en}) begin
          dat = q.bits[8:1] & ufcs_pkg::ufcs_mask(data_length_sel);
          d.rx_st = ufcs_pkg::ST_IDLE;
          d.vld = 1'b1;
          d.data = dat;
          d.xbit = ext_en ? q.bits[slot] : q.sync[1];
          d.perr = parity_enable_bit && q.bits[slot] !=
              ufcs_pkg::ufcs_parity(dat, data_length_sel, parity_type_sel);
          d.serr = ~q.sync[1];
        end
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q <= '0;
      q.sync <= 2'h3;
      q.line <= 1'b1;
    end else begin
      q <= d;
    end
  end
endmodule

// ===== bench/ufcs_link_checker.sv
// wire-level checks of the serial link between the two ends
`timescale 1ns/100ps
module ufcs_link_checker #(
  parameter int unsigned HALF_BIT = 8
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic dev_tx,
  input wire logic node_tx
);
  localparam int unsigned BIT = 2 * HALF_BIT;
  // ------------------------------------------------------------
  // run length of the present level on each line
  // ------------------------------------------------------------
  typedef struct packed {
    logic dev_l;
    logic node_l;
    logic [15:0] dev_run;
    logic [15:0] node_run;
  } ufcs_chk_t;
  ufcs_chk_t s_q, s_d;
  always_comb begin
    s_d = s_q;
    s_d.dev_l = dev_tx;
    s_d.node_l = node_tx;
    s_d.dev_run = (dev_tx != s_q.dev_l) ? 16'h0001 : s_q.dev_run + 16'h0001;
    s_d.node_run = (node_tx != s_q.node_l) ? 16'h0001 :
        s_q.node_run + 16'h0001;
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q <= {1'b1, 1'b1, 16'h0000, 16'h0000};
    end else begin
      s_q <= s_d;
    end
  end
  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  link_idle_a:
    assert property ($rose(hresetn) |-> dev_tx && node_tx)
      else $error("line not idle high after reset");
  dev_bit_min_a:
    assert property ($changed(dev_tx) |-> s_q.dev_run >= BIT)
      else $error("device line level shorter than one bit");
  node_bit_min_a:
    assert property ($changed(node_tx) |-> s_q.node_run >= BIT)
      else $error("node line level shorter than one bit");
  dev_low_grid_a:
    assert property ($rose(dev_tx) |-> (s_q.dev_run % BIT) == 0)
      else $error("device low run off the bit grid");
  node_low_grid_a:
    assert property ($rose(node_tx) |-> (s_q.node_run % BIT) == 0)
      else $error("node low run off the bit grid");
  dev_low_max_a:
    assert property ($rose(dev_tx) |-> s_q.dev_run <= 10 * BIT)
      else $error("device low run longer than a frame body");
  node_low_max_a:
    assert property ($rose(node_tx) |-> s_q.node_run <= 10 * BIT)
      else $error("node low run longer than a frame body");
  dev_frame_end_a:
    assert property ($fell(dev_tx) |-> ##[1:200] dev_tx)
      else $error("device frame without high stop");
endmodule

// ===== bench/uart_frame_control_status_tb.sv
// self-checking bench: register bus on the device, node on the far end
`timescale 1ns/100ps
module uart_frame_control_status_tb;
  localparam int unsigned HB = 4;
  localparam logic [31:0] A_SCS = {ufcs_pkg::IDX_SCS, 2'h0};
  localparam logic [31:0] A_SDB = {ufcs_pkg::IDX_SDB, 2'h0};
  localparam logic [31:0] A_FFC = {ufcs_pkg::IDX_FFC, 2'h0};
  localparam logic [31:0] A_NONE = 32'h00000300;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq_req, got;
  logic [31:0] haddr, hwdata, hrdata, v;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [7:0] nfmt, tx_data, rx_data, c, d, m;
  logic tx_valid, tx_ready, tx_extra, rx_valid, rx_extra, rx_perr, rx_serr;
  int error_cnt, total_checks;
  ufcs_link_if ufcs_link_if_i ();
  ufcs_dev_end #(.HALF_BIT(HB)) ufcs_dev_end_i (.hclk(hclk),
    .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .irq_req(irq_req), .link(ufcs_link_if_i.dev));
  ufcs_node_end #(.HALF_BIT(HB)) ufcs_node_end_i (.hclk(hclk),
    .hresetn(hresetn), .link(ufcs_link_if_i.node),
    .data_length_sel(nfmt[3:2]), .parity_enable_bit(nfmt[4]),
    .parity_type_sel(nfmt[6:5]), .extra_bit_mode(nfmt[1]),
    .stop_length_sel(nfmt[0]), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .tx_data(tx_data), .tx_extra(tx_extra), .rx_valid(rx_valid),
    .rx_data(rx_data), .rx_extra(rx_extra), .rx_parity_err(rx_perr),
    .rx_stop_err(rx_serr));
  ufcs_link_checker #(.HALF_BIT(HB)) ufcs_link_checker_i (.hclk(hclk),
    .hresetn(hresetn), .dev_tx(ufcs_link_if_i.dev_tx),
    .node_tx(ufcs_link_if_i.node_tx));
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic results();
    $display("checks %0d, mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [31:0] a,
      input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= a;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    v = hrdata;
  endtask
  task automatic rd_chk(input logic [31:0] a, input logic [31:0] msk,
      input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    check(v & msk, exp);
  endtask
  task automatic wait_rx();
    got = 1'b0;
    for (int i = 0; i < 400; i++) begin
      @(posedge hclk);
      if (rx_valid === 1'b1) begin
        got = 1'b1;
        break;
      end
    end
  endtask
  task automatic rx_chk(input logic [7:0] dx, input logic x,
      input logic p, input logic pe_exp);
    wait_rx();
    check(got, 1'b1);
    check(rx_data, dx);
    check(rx_extra | p, x | p);
    check(rx_perr, pe_exp);
    check(rx_serr, 1'b0);
  endtask
  task automatic node_send(input logic [7:0] dx, input logic x);
    tx_data <= dx;
    tx_extra <= x;
    tx_valid <= 1'b1;
    @(posedge hclk);
    while (tx_ready !== 1'b1) @(posedge hclk);
    tx_valid <= 1'b0;
    repeat (2) @(posedge hclk);
    while (tx_ready !== 1'b1) @(posedge hclk);
  endtask
  initial begin
    repeat (40000) @(posedge hclk);
    error_cnt++;
    results();
  end
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    nfmt = 8'h0C;
    tx_valid = 1'b0;
    tx_data = 8'h00;
    tx_extra = 1'b0;
    error_cnt = 0;
    total_checks = 0;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd_chk(A_SCS, 32'hFF, 32'h20);
    check({hreadyout, hresp}, 32'h2);
    rd_chk(A_FFC, 32'hFF, 32'h0C);
    bus(1'b1, A_NONE, 32'hFF);
    rd_chk(A_NONE, 32'hFFFFFFFF, 32'h0);
    $display("test reset values done");
    for (int i = 0; i < 4; i++) begin
      c = {1'b0, 2'(i), i[0], 2'(i), ~i[0], i != 3};
      nfmt <= c;
      bus(1'b1, A_FFC, {24'h0, c});
      bus(1'b1, A_SCS, {28'h0, i[1], 3'h0});
      d = 8'hA5 ^ 8'(i);
      m = 8'hFF >> (3 - i);
      bus(1'b1, A_SDB, {24'h0, d});
      bus(1'b1, A_SDB, {24'h0, ~d});
      rd_chk(A_SCS, 32'h20, 32'h0);
      bus(1'b1, A_SDB, 32'h0);
      rx_chk(d & m, c[1] ? i[1] : 1'b1, c[4], 1'b0);
      rx_chk(~d & m, c[1] ? i[1] : 1'b1, c[4], 1'b0);
      wait_rx();
      check(got, 1'b0);
      rd_chk(A_SCS, 32'h02, 32'h02);
      check(irq_req, 1'b1);
      bus(1'b1, A_SCS, 32'h0);
      rd_chk(A_SCS, 32'h02, 32'h0);
      check(irq_req, 1'b0);
    end
    $display("test transmit formats done");
    bus(1'b1, A_FFC, 32'h1C);
    nfmt <= 8'h3C;
    bus(1'b1, A_SDB, 32'h5A);
    rx_chk(8'h5A, 1'b1, 1'b1, 1'b1);
    bus(1'b1, A_SCS, 32'h10);
    node_send(8'h01, 1'b0);
    rd_chk(A_SCS, 32'h40, 32'h40);
    bus(1'b0, A_SDB, 32'h0);
    rd_chk(A_SCS, 32'h40, 32'h40);
    bus(1'b1, A_SCS, 32'h10);
    rd_chk(A_SCS, 32'h41, 32'h0);
    bus(1'b1, A_FFC, 32'h5C);
    nfmt <= 8'h5C;
    bus(1'b1, A_SDB, 32'h3C);
    rx_chk(8'h3C, 1'b1, 1'b1, 1'b0);
    node_send(8'h3C, 1'b0);
    rd_chk(A_SCS, 32'h40, 32'h0);
    rd_chk(A_SDB, 32'hFF, 32'h3C);
    $display("test parity done");
    bus(1'b1, A_FFC, 32'h0C);
    nfmt <= 8'h0C;
    bus(1'b1, A_SCS, 32'h0);
    node_send(8'h11, 1'b0);
    rd_chk(A_SCS, 32'hFF, 32'h20);
    bus(1'b1, A_SCS, 32'h10);
    for (int k = 0; k < 4; k++) begin
      node_send(8'h21 + 8'(k) * 8'h11, 1'b0);
    end
    rd_chk(A_SCS, 32'hFF, 32'hB5);
    check(irq_req, 1'b1);
    rd_chk(A_SDB, 32'hFF, 32'h21);
    rd_chk(A_SCS, 32'h80, 32'h80);
    bus(1'b1, A_SCS, 32'h10);
    rd_chk(A_SCS, 32'h81, 32'h01);
    rd_chk(A_SDB, 32'hFF, 32'h32);
    bus(1'b1, A_SCS, 32'h10);
    rd_chk(A_SCS, 32'h01, 32'h0);
    rd_chk(A_SDB, 32'hFF, 32'h43);
    $display("test receive queue done");
    bus(1'b1, A_FFC, 32'h8E);
    nfmt <= 8'h8E;
    node_send(8'h77, 1'b0);
    rd_chk(A_SCS, 32'h05, 32'h0);
    node_send(8'h88, 1'b1);
    rd_chk(A_SCS, 32'h01, 32'h01);
    rd_chk(A_SDB, 32'hFF, 32'h77);
    rd_chk(A_SCS, 32'h04, 32'h04);
    rd_chk(A_SDB, 32'hFF, 32'h88);
    $display("test multiprocessor done");
    results();
  end
endmodule
